// ---- hdl/dcs_channel_ctrl.sv ----
// Overview of operation
// R1: Cleared enable finishes current unit, then stops
// R2: Enable written 1 resumes; master enable likewise
// R3: Short mode: four end interrupts, 0A highest
// R4: Full mode: end0, break0, end1, break1 lines
// R5: Each line gated by own enable, separate
// R6: End request while end-enable 1, enable 0
// R7: Break request while master 0, break-enable 1
// R8: Software avoids transient interrupt combinations
// R9: Software changes settings only while disabled
// R10: Address steps one cycle before bus cycle
// R11: Module stop freezes clock, blocks register access
// R12: Module stop write ignored while channel enabled
// R13: Interrupt, end pin, ack pin persist stopped
// R14: Write buffer lets next operation start early
// R15: End pulse omitted on overlapped internal cycle
// R16: External final cycle drives end pin low
// R17: End pin may stay low into refresh
// R18: Edge detector: low, transfer, high states
// R19: Enabling enters low-level wait state
// R20: Already-low pin or pending interrupt accepted
// R21: Interrupt passes on when enable clears
// R22: Cleared enable must read 0 before set
`timescale 1ns/1ps
module dcs_channel_ctrl (
  input  wire logic                       clk_sys,
  input  wire logic                       rst_b,
  input  wire logic                       ce,
  input  wire logic [dcs_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [dcs_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [dcs_pkg::DATA_W-1:0] reg_rdata,
  input  wire logic [3:0]                 transfer_request_in_b,
  input  wire logic [3:0]                 int_req_in,
  input  wire logic [3:0]                 bus_grant,
  input  wire logic [3:0]                 unit_done,
  input  wire logic [3:0]                 unit_last,
  input  wire logic [3:0]                 final_cycle,
  input  wire logic                       ext_target,
  input  wire logic                       par_ext_busy,
  input  wire logic                       cas_before_ras,
  input  wire logic                       write_buffer_enable,
  output logic      [3:0]                 act_req,
  output logic      [3:0]                 mar_step,
  output logic      [3:0]                 cycle_go,
  output logic      [3:0]                 src_clear,
  output logic      [3:0]                 int_pass,
  output logic      [3:0]                 transfer_ack_out_b,
  output logic      [1:0]                 transfer_end_out_b,
  output logic                            irq_line_ch0_first,
  output logic                            irq_line_ch0_second,
  output logic                            irq_line_ch1_first,
  output logic                            irq_line_ch1_second,
  output logic                            module_stopped
);
  localparam int unsigned NS = dcs_pkg::N_SUB;

  // Spread a per-channel bit onto both of its sub-channels
  function automatic logic [3:0] per_sub(input logic [1:0] ch);
    per_sub = {ch[1], ch[1], ch[0], ch[0]};
  endfunction : per_sub

  // Registers
  logic [dcs_pkg::CL_W-1:0]   ctrl_low_r;
  logic [dcs_pkg::CL_W-1:0]   ctrl_low_nxt;
  logic [dcs_pkg::CH_W-1:0]   ctrl_high_r;
  logic                       mstop_r;
  logic                       mstop_nxt;
  logic [NS-1:0]              arm_r;
  logic [NS-1:0]              arm_nxt;
  logic [NS-1:0]              busy_r;
  logic [NS-1:0]              busy_nxt;
  logic [NS-1:0]              act_req_nxt;
  logic [NS-1:0]              irq_nxt;
  logic [1:0]                 transfer_end_out_low_r;
  logic [1:0]                 transfer_end_out_low_nxt;
  logic [dcs_pkg::DATA_W-1:0] rdata_nxt;

  // Field views
  wire  [NS-1:0]              channel_transfer_enable     = ctrl_low_r[dcs_pkg::CL_DTE_LSB +: NS];
  wire  [NS-1:0]              end_irq_enable    = ctrl_low_r[dcs_pkg::CL_END_IRQ_ENABLE_LSB +: NS];
  wire  [1:0]                 fae     = ctrl_high_r[dcs_pkg::CH_FAE_LSB +: 2];
  wire  [NS-1:0]              single_address_select     = ctrl_high_r[dcs_pkg::CH_SAE_LSB +: NS];
  wire  [NS-1:0]              source_clear_enable     = ctrl_high_r[dcs_pkg::CH_DTA_LSB +: NS];
  wire  [NS-1:0]              end_pin_enable     = ctrl_high_r[dcs_pkg::CH_TEE_LSB +: NS];
  wire  [NS-1:0]              edge_s  = ctrl_high_r[dcs_pkg::CH_EDGE_LSB +: NS];
  wire  [NS-1:0]              pin_s   = ctrl_high_r[dcs_pkg::CH_PIN_LSB +: NS];
  wire  [NS-1:0]              fae_sub = per_sub(fae);

  // Engine runs only with clock enable and outside module stop
  wire                        run     = ce & ~mstop_r;                 // [R11]

  // Register port decode
  wire                        acc_ok  = ce & ~mstop_r;                 // [R11]
  wire                        wr_low  = reg_wr & acc_ok & (reg_addr == dcs_pkg::REG_CTRL_LOW);
  wire                        wr_high = reg_wr & acc_ok & (reg_addr == dcs_pkg::REG_CTRL_HIGH);
  wire                        rd_low  = reg_rd & acc_ok & (reg_addr == dcs_pkg::REG_CTRL_LOW);
  wire                        wr_stop = reg_wr & ce & (reg_addr == dcs_pkg::REG_MOD_STOP);

  // Pin synchronisation, active-low request pins
  logic [NS-1:0]              pin_sync;
  wire  [NS-1:0]              pin_low = ~pin_sync;

  dcs_sync2 #(
    .W       (NS),
    .RST_VAL (dcs_pkg::PIN_IDLE_RST)
  ) u_pin_sync (
    .clk_sys (clk_sys),
    .rst_b   (rst_b),
    .ce      (ce),
    .d       (transfer_request_in_b),
    .q       (pin_sync)
  );

  // Effective enable per sub-channel; full mode uses B enable as master
  logic [NS-1:0] en;
  logic [NS-1:0] edge_pend;
  logic [NS-1:0] pend;
  logic [NS-1:0] accept;
  logic [NS-1:0] fin;
  logic [NS-1:0] hw_clr;

  genvar k;
  generate
    for (k = 0; k < NS; k = k + 1) begin : g_sub
      if ((k % 2) == 0) begin : g_a
        assign en[k] = fae_sub[k] ? (channel_transfer_enable[k] & channel_transfer_enable[k+1]) : channel_transfer_enable[k];     // [R2]
      end else begin : g_b
        assign en[k] = ~fae_sub[k] & channel_transfer_enable[k];
      end

      // Falling-edge detector for pin-sourced edge activation
      dcs_edge_det u_edge (
        .clk_sys (clk_sys),
        .rst_b   (rst_b),
        .run     (run),
        .enable  (en[k] & edge_s[k] & pin_s[k]),
        .req_low (pin_low[k]),
        .grant   (accept[k]),
        .pend    (edge_pend[k])
      );

      // Pending source: pin edge, pin level, or internal request
      assign pend[k] = pin_s[k] ? (edge_s[k] ? edge_pend[k] : pin_low[k])
                                : int_req_in[k];                         // [R20]
    end
  endgenerate

  // A grant is taken only against a held request
  assign accept = bus_grant & act_req;

  // Unit finishes at cycle start with write buffer, else at done
  assign fin    = write_buffer_enable ? cycle_go : unit_done;          // [R14]

  // Hardware clears enable when the final unit completes
  assign hw_clr = unit_done & unit_last & busy_r;

  // Busy holds through the unit even when enable drops
  always_comb begin
    busy_nxt = busy_r;
    for (int i = 0; i < NS; i++) begin
      if (accept[i]) busy_nxt[i] = 1'b1;
      else if (fin[i]) busy_nxt[i] = 1'b0;                             // [R1]
    end
  end

  // New request only while enabled and idle
  assign act_req_nxt = en & pend & ~busy_nxt;                          // [R1]

  // Enable bits: a set after a clear needs a read of zero (reset arms all), hardware clear wins
  logic [NS-1:0] dte_wr;
  logic [NS-1:0] dte_nxt;
  assign dte_wr  = reg_wdata[dcs_pkg::CL_DTE_LSB +: NS] & (channel_transfer_enable | arm_r); // [R22]
  assign dte_nxt = (wr_low ? dte_wr : channel_transfer_enable) & ~hw_clr;                   // [R2]

  always_comb begin
    ctrl_low_nxt = ctrl_low_r;
    if (wr_low) ctrl_low_nxt = reg_wdata[dcs_pkg::CL_W-1:0];
    ctrl_low_nxt[dcs_pkg::CL_DTE_LSB +: NS] = dte_nxt;
  end

  // Rearm after the cleared bit has been read as zero
  always_comb begin
    arm_nxt = arm_r;
    for (int i = 0; i < NS; i++) begin
      if (channel_transfer_enable[i] & ~dte_nxt[i]) arm_nxt[i] = 1'b0;                      // [R22]
      else if (rd_low & ~channel_transfer_enable[i]) arm_nxt[i] = 1'b1;                     // [R22]
    end
  end

  // Module stop request refused while any channel is enabled
  always_comb begin
    mstop_nxt = mstop_r;
    if (wr_stop) begin
      if (!reg_wdata[dcs_pkg::MSTOP_BIT]) mstop_nxt = 1'b0;
      else if (~|channel_transfer_enable) mstop_nxt = 1'b1;                                 // [R12]
    end
  end

  // Uniform end/break condition: enable 0 with its interrupt enable 1
  assign irq_nxt = end_irq_enable & ~channel_transfer_enable;                                        // [R5] [R6] [R7]

  // End pin: low on final cycle unless overlapped internally
  always_comb begin
    for (int c = 0; c < dcs_pkg::N_CH; c++) begin
      transfer_end_out_low_nxt[c] = (|(final_cycle[2*c +: 2] & end_pin_enable[2*c +: 2]))
                        & (ext_target | ~par_ext_busy);                // [R15] [R16]
      if (transfer_end_out_low_r[c] & cas_before_ras) transfer_end_out_low_nxt[c] = 1'b1;      // [R17]
    end
  end

  // Read data mux
  always_comb begin
    rdata_nxt = '0;
    if (reg_rd & ce) begin
      case (reg_addr)
        dcs_pkg::REG_CTRL_LOW: begin
          if (!mstop_r) rdata_nxt[dcs_pkg::CL_W-1:0] = ctrl_low_r;
        end
        dcs_pkg::REG_CTRL_HIGH: begin
          if (!mstop_r) rdata_nxt[dcs_pkg::CH_W-1:0] = ctrl_high_r;
        end
        dcs_pkg::REG_MOD_STOP: begin
          rdata_nxt[dcs_pkg::MSTOP_BIT] = mstop_r;
        end
        dcs_pkg::REG_STATUS: begin
          if (!mstop_r) begin
            rdata_nxt[dcs_pkg::ST_BUSY_LSB +: NS] = busy_r;
            rdata_nxt[dcs_pkg::ST_REQ_LSB +: NS]  = act_req;
            rdata_nxt[dcs_pkg::ST_IRQ_LSB +: NS]  = irq_nxt;
          end
          rdata_nxt[dcs_pkg::ST_MSTOP_BIT] = mstop_r;
        end
        default: rdata_nxt = '0;
      endcase
    end
  end

  // Register file; frozen contents keep their effect in module stop
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_low_r  <= dcs_pkg::CTRL_LOW_RST;
      ctrl_high_r <= dcs_pkg::CTRL_HIGH_RST;
      arm_r       <= dcs_pkg::ARM_RST;
    end else if (run) begin
      ctrl_low_r  <= ctrl_low_nxt;
      arm_r       <= arm_nxt;
      if (wr_high) ctrl_high_r <= reg_wdata[dcs_pkg::CH_W-1:0];
    end
  end

  // Module stop bit and read data answer
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mstop_r        <= dcs_pkg::MSTOP_RST;
      module_stopped <= dcs_pkg::MSTOP_RST;
      reg_rdata      <= '0;
    end else if (ce) begin
      mstop_r        <= mstop_nxt;                                     // [R11]
      module_stopped <= mstop_nxt;
      reg_rdata      <= rdata_nxt;
    end
  end

  // Transfer engine state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      busy_r  <= '0;
      act_req <= '0;
    end else if (run) begin
      busy_r  <= busy_nxt;
      act_req <= act_req_nxt;                                          // [R20]
    end
  end

  // Address step leads the bus cycle by one clock
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      mar_step <= '0;
      cycle_go <= '0;
    end else if (run) begin
      mar_step <= accept;                                              // [R10]
      cycle_go <= mar_step;                                            // [R10]
    end
  end

  // Source clearing and pass-through of internal requests
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      src_clear <= '0;
      int_pass  <= '0;
    end else if (run) begin
      src_clear <= accept & source_clear_enable & ~pin_s;
      int_pass  <= int_req_in & (pin_s | ~source_clear_enable | ~en);                  // [R21]
    end
  end

  // Pins and interrupt lines hold their last value while stopped
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      transfer_ack_out_b  <= '1;
      transfer_end_out_low_r          <= '0;
      transfer_end_out_b  <= '1;
      irq_line_ch0_first  <= 1'b0;
      irq_line_ch0_second <= 1'b0;
      irq_line_ch1_first  <= 1'b0;
      irq_line_ch1_second <= 1'b0;
    end else if (run) begin
      transfer_ack_out_b  <= ~(busy_nxt & single_address_select & ~fae_sub);             // [R13]
      transfer_end_out_low_r          <= transfer_end_out_low_nxt;
      transfer_end_out_b  <= ~transfer_end_out_low_nxt;                            // [R16]
      irq_line_ch0_first  <= irq_nxt[0];                               // [R3] [R4]
      irq_line_ch0_second <= irq_nxt[1];                               // [R3] [R4]
      irq_line_ch1_first  <= irq_nxt[2];                               // [R3] [R4]
      irq_line_ch1_second <= irq_nxt[3];                               // [R3] [R4] [R13]
    end
  end
endmodule : dcs_channel_ctrl

// ---- hdl/dcs_pkg.sv ----
package dcs_pkg;
  // Register word indices on the plain register port
  localparam int unsigned ADDR_W          = 2;
  localparam int unsigned DATA_W          = 32;
  localparam logic [1:0]  REG_CTRL_LOW    = 2'h0;
  localparam logic [1:0]  REG_CTRL_HIGH   = 2'h1;
  localparam logic [1:0]  REG_MOD_STOP    = 2'h2;
  localparam logic [1:0]  REG_STATUS      = 2'h3;

  // Sub-channel count (0A, 0B, 1A, 1B) and channel count
  localparam int unsigned N_SUB           = 4;
  localparam int unsigned N_CH            = 2;

  // channel_control_low fields
  localparam int unsigned CL_W            = 8;
  localparam int unsigned CL_DTE_LSB      = 0;
  localparam int unsigned CL_END_IRQ_ENABLE_LSB     = 4;

  // channel_control_high fields
  localparam int unsigned CH_W            = 22;
  localparam int unsigned CH_FAE_LSB      = 0;
  localparam int unsigned CH_SAE_LSB      = 2;
  localparam int unsigned CH_DTA_LSB      = 6;
  localparam int unsigned CH_TEE_LSB      = 10;
  localparam int unsigned CH_EDGE_LSB     = 14;
  localparam int unsigned CH_PIN_LSB      = 18;

  // Status fields
  localparam int unsigned ST_BUSY_LSB     = 0;
  localparam int unsigned ST_REQ_LSB      = 4;
  localparam int unsigned ST_IRQ_LSB      = 8;
  localparam int unsigned ST_MSTOP_BIT    = 12;
  localparam int unsigned MSTOP_BIT       = 0;

  // Values after reset
  localparam logic [CL_W-1:0]   CTRL_LOW_RST  = 8'h00;
  localparam logic [CH_W-1:0]   CTRL_HIGH_RST = 22'h000000;
  localparam logic              MSTOP_RST     = 1'b0;
  localparam logic [N_SUB-1:0]  ARM_RST       = 4'hF;
  localparam logic [N_SUB-1:0]  PIN_IDLE_RST  = 4'hF;

  // Address lead ahead of the bus cycle, in clock cycles
  localparam int unsigned MAR_LEAD_CYC    = 1;

  // Falling-edge request detector states
  typedef enum logic [1:0] {
    EDGE_WAIT_LOW,
    EDGE_WAIT_XFER,
    EDGE_WAIT_HIGH
  } dcs_edge_state_type;
endpackage : dcs_pkg

// ---- hdl/dcs_sync2.sv ----
`timescale 1ns/1ps
module dcs_sync2 #(
  parameter int unsigned        W       = 4,
  parameter logic [W-1:0]       RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst_b,
  input  wire logic             ce,
  input  wire logic [W-1:0]     d,
  output logic      [W-1:0]     q
);
  logic [W-1:0] meta_r;

  // Two-stage synchroniser, first stage read only by second
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_r <= RST_VAL;
      q      <= RST_VAL;
    end else if (ce) begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : dcs_sync2

// ---- hdl/dcs_edge_det.sv ----
`timescale 1ns/1ps
module dcs_edge_det (
  input  wire logic clk_sys,
  input  wire logic rst_b,
  input  wire logic run,
  input  wire logic enable,
  input  wire logic req_low,
  input  wire logic grant,
  output logic      pend
);
  dcs_pkg::dcs_edge_state_type state_r;
  dcs_pkg::dcs_edge_state_type state_nxt;

  // Three-state detector, restarts at low-level wait when disabled
  always_comb begin
    state_nxt = state_r;
    if (!enable) begin
      state_nxt = dcs_pkg::EDGE_WAIT_LOW;                       // [R19]
    end else begin
      case (state_r)
        dcs_pkg::EDGE_WAIT_LOW: begin
          if (req_low) state_nxt = dcs_pkg::EDGE_WAIT_XFER;     // [R18]
        end
        dcs_pkg::EDGE_WAIT_XFER: begin
          if (grant) state_nxt = dcs_pkg::EDGE_WAIT_HIGH;       // [R18]
        end
        dcs_pkg::EDGE_WAIT_HIGH: begin
          if (!req_low) state_nxt = dcs_pkg::EDGE_WAIT_LOW;     // [R18]
        end
        default: state_nxt = dcs_pkg::EDGE_WAIT_LOW;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) state_r <= dcs_pkg::EDGE_WAIT_LOW;
    else if (run) state_r <= state_nxt;
  end

  assign pend = (state_r == dcs_pkg::EDGE_WAIT_XFER);
endmodule : dcs_edge_det

// ---- dv/dcs_channel_ctrl_props.sv ----
`timescale 1ns/1ps
module dcs_channel_ctrl_props (
  input wire logic        clk_sys,
  input wire logic        rst_b,
  input wire logic        ce,
  input wire logic [1:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [3:0]  bus_grant,
  input wire logic [3:0]  final_cycle,
  input wire logic        cas_before_ras,
  input wire logic        write_buffer_enable,
  input wire logic [3:0]  act_req,
  input wire logic [3:0]  mar_step,
  input wire logic [3:0]  cycle_go,
  input wire logic [3:0]  transfer_ack_out_b,
  input wire logic [1:0]  transfer_end_out_b,
  input wire logic        irq_line_ch0_first,
  input wire logic        irq_line_ch0_second,
  input wire logic        irq_line_ch1_first,
  input wire logic        irq_line_ch1_second,
  input wire logic        module_stopped
);
  // Accepted write to the low control word
  wire wr_low = ce && reg_wr && reg_addr == dcs_pkg::REG_CTRL_LOW && !module_stopped;
  wire taken0 = ce && bus_grant[0] && act_req[0] && !module_stopped;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);

  // Bus cycle sequencing and request handling
  AST_MAR_LEAD: assert property (taken0 |=> mar_step[0] ##1 cycle_go[0])
    else $error("address step does not lead the cycle start");
  AST_REQ_CLEARED: assert property (taken0 |=> !act_req[0])
    else $error("request still held after grant");
  // Interrupt lines against the enable bits written
  AST_END_IRQ: assert property (wr_low && reg_wdata[4] && !reg_wdata[0] |=> ##[0:1] irq_line_ch0_first)
    else $error("end interrupt missing");
  AST_BREAK_IRQ: assert property (wr_low && reg_wdata[5] && !reg_wdata[1] |=> ##[0:1] irq_line_ch0_second)
    else $error("second interrupt of channel 0 missing");
  AST_CH1_IRQ: assert property (wr_low && reg_wdata[6] && !reg_wdata[2] |=> ##[0:1] irq_line_ch1_first)
    else $error("first interrupt of channel 1 missing");
  AST_IRQ_GATED: assert property (wr_low && !reg_wdata[7] |=> ##[0:1] !irq_line_ch1_second)
    else $error("masked interrupt still raised");
  // Module stop behaviour
  AST_STOP_READ: assert property (reg_rd && module_stopped && reg_addr == dcs_pkg::REG_CTRL_LOW |=> reg_rdata == 32'h0)
    else $error("control word readable in module stop");
  AST_STATUS_STOP: assert property (reg_rd && reg_addr == dcs_pkg::REG_STATUS |=> reg_rdata[dcs_pkg::ST_MSTOP_BIT] == $past(module_stopped))
    else $error("status stop bit wrong");
  AST_STOP_FREEZE: assert property (module_stopped |=> $stable({irq_line_ch0_first, irq_line_ch0_second, irq_line_ch1_first, irq_line_ch1_second, transfer_end_out_b, transfer_ack_out_b}))
    else $error("outputs moved in module stop");
  // Write buffer: the unit ends at cycle start, acknowledge released
  AST_WB_EARLY: assert property (write_buffer_enable && cycle_go[0] && !(bus_grant[0] && act_req[0]) && !module_stopped |=> transfer_ack_out_b[0])
    else $error("unit not ended at cycle start with write buffer");
  // End pin idles high without a final cycle
  AST_END_IDLE: assert property (final_cycle == 4'h0 && !cas_before_ras && !module_stopped |=> transfer_end_out_b == 2'h3)
    else $error("end pin low without final cycle");
endmodule : dcs_channel_ctrl_props

bind dcs_channel_ctrl dcs_channel_ctrl_props u_dcs_channel_ctrl_props (.*);

// ---- dv/dcs_ext_periph.sv ----
`timescale 1ns/1ps
module dcs_ext_periph (
  input  wire logic       clk_sys,
  input  wire logic       rst_b,
  input  wire logic [3:0] want,
  input  wire logic [3:0] transfer_ack_out_b,
  input  wire logic [1:0] transfer_end_out_b,
  output logic      [3:0] transfer_request_in_b,
  output int              ends_seen
);
  logic [3:0] served_r;

  // One request per want period, dropped once acknowledged; counts clock cycles with an end pin low
  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      served_r  <= 4'h0;
      ends_seen <= 0;
    end else begin
      served_r <= (served_r | ~transfer_ack_out_b) & want;
      if (transfer_end_out_b != 2'h3) ends_seen <= ends_seen + 1;
    end
  end
  // Released pins float up to the pull-up level
  assign transfer_request_in_b = ~(want & ~served_r);
endmodule : dcs_ext_periph

// ---- dv/dcs_channel_ctrl_tb_top.sv ----
`timescale 1ns/1ps
module dcs_channel_ctrl_tb_top;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic        ext_target = 1'b0;
  logic        par_ext_busy = 1'b0;
  logic        cas_before_ras = 1'b0;
  logic        write_buffer_enable = 1'b0;
  logic        hold = 1'b0;
  logic [1:0]  reg_addr = 2'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic [3:0]  int_req_in = 4'h0;
  logic [3:0]  int_set = 4'h0;
  logic [3:0]  bus_grant = 4'h0;
  logic [3:0]  unit_done = 4'h0;
  logic [3:0]  unit_last = 4'h0;
  logic [3:0]  final_cycle = 4'h0;
  logic [3:0]  last_mask = 4'h0;
  logic [3:0]  pend_r = 4'h0;
  logic [3:0]  want = 4'h0;
  logic [31:0] reg_rdata, d;
  logic [3:0]  transfer_request_in_b, act_req, mar_step, cycle_go, src_clear, int_pass;
  logic [3:0]  transfer_ack_out_b;
  logic [1:0]  transfer_end_out_b;
  logic        irq_line_ch0_first, irq_line_ch0_second, irq_line_ch1_first, irq_line_ch1_second;
  logic        module_stopped;
  int          ends_seen, n0, bad_count = 0, checks = 0;
  wire  [3:0]  irq = {irq_line_ch1_second, irq_line_ch1_first, irq_line_ch0_second,
                      irq_line_ch0_first};

  dcs_channel_ctrl u_dcs_channel_ctrl (.*);

  dcs_ext_periph u_dcs_ext_periph (
    .clk_sys               (clk_sys),
    .rst_b                 (rst_b),
    .want                  (want),
    .transfer_ack_out_b    (transfer_ack_out_b),
    .transfer_end_out_b    (transfer_end_out_b),
    .transfer_request_in_b (transfer_request_in_b),
    .ends_seen             (ends_seen)
  );

  always #10 clk_sys = ~clk_sys;

  // Bus controller stand-in: grants a request, ends the unit unless held
  always @(posedge clk_sys) begin
    bus_grant   <= act_req & ~bus_grant;
    pend_r      <= (pend_r | cycle_go) & {4{hold}};
    unit_done   <= (pend_r | cycle_go) & ~{4{hold}};
    unit_last   <= (pend_r | cycle_go) & ~{4{hold}} & last_mask;
    final_cycle <= (pend_r | cycle_go) & ~{4{hold}} & last_mask;
    int_req_in  <= (int_req_in | int_set) & ~src_clear;
  end

  task automatic wr(input logic [1:0] a, input logic [31:0] v);
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk_sys);
    reg_wr    <= 1'b0;
  endtask : wr

  task automatic rd(input logic [1:0] a);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk_sys);
    reg_rd   <= 1'b0;
    @(negedge clk_sys);
    d = reg_rdata;
  endtask : rd

  task automatic look(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : look

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Bounded wait for the acknowledge of one sub-channel
  task automatic wait_ack(input int k);
    for (int i = 0; i < 40 && transfer_ack_out_b[k] !== 1'b0; i++) @(negedge clk_sys);
    chk({31'h0, transfer_ack_out_b[k]}, 32'h0);
  endtask : wait_ack

  task automatic report_and_stop;
    $display("Checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : report_and_stop

  // Watchdog well beyond the few hundred cycles the sequence needs
  initial begin
    repeat (20000) @(posedge clk_sys);
    bad_count++;
    report_and_stop;
  end

  // Main sequence
  initial begin
    repeat (10) @(posedge clk_sys);
    rst_b <= 1'b1;
    for (int a = 0; a < 4; a++) begin
      rd(a[1:0]);
      chk(d, 32'h0);
    end
    // Interrupt lines in both address modes
    wr(dcs_pkg::REG_CTRL_LOW, 32'hF0);
    look(2);
    chk(irq, 4'hF);
    wr(dcs_pkg::REG_CTRL_LOW, 32'h50);
    look(2);
    chk(irq, 4'h5);
    wr(dcs_pkg::REG_CTRL_HIGH, 32'h1);
    wr(dcs_pkg::REG_CTRL_LOW, 32'h30);
    look(2);
    chk(irq, 4'h3);
    // Level request on pin 0A, stop refused while enabled
    wr(dcs_pkg::REG_CTRL_HIGH, 32'h40404);
    rd(dcs_pkg::REG_CTRL_LOW);
    wr(dcs_pkg::REG_CTRL_LOW, 32'h11);
    wr(dcs_pkg::REG_MOD_STOP, 32'h1);
    rd(dcs_pkg::REG_MOD_STOP);
    chk(d, 32'h0);
    chk(irq, 4'h0);
    hold = 1'b1;
    want <= 4'h1;
    wait_ack(0);
    // Forced stop mid-unit: the unit in flight completes first
    wr(dcs_pkg::REG_CTRL_LOW, 32'h10);
    rd(dcs_pkg::REG_STATUS);
    chk(d[0], 1'b1);
    hold = 1'b0;
    look(4);
    rd(dcs_pkg::REG_STATUS);
    chk(d[11:0], 12'h100);
    // Re-enable only after the cleared bit was read
    wr(dcs_pkg::REG_CTRL_LOW, 32'h11);
    rd(dcs_pkg::REG_CTRL_LOW);
    chk(d[0], 1'b0);
    wr(dcs_pkg::REG_CTRL_LOW, 32'h11);
    rd(dcs_pkg::REG_CTRL_LOW);
    chk(d[0], 1'b1);
    // Final unit on an external cycle pulses the end pin
    n0 = ends_seen;
    last_mask = 4'h1;
    want <= 4'h0;
    @(posedge clk_sys);
    ext_target <= 1'b1;
    want <= 4'h1;
    wait_ack(0);
    look(8);
    chk(32'(ends_seen - n0), 32'h1);
    chk(irq[0], 1'b1);
    // Internal final cycle beside a parallel external cycle: no pulse
    rd(dcs_pkg::REG_CTRL_LOW);
    @(posedge clk_sys);
    ext_target <= 1'b0;
    par_ext_busy <= 1'b1;
    want <= 4'h0;
    n0 = ends_seen;
    wr(dcs_pkg::REG_CTRL_LOW, 32'h11);
    want <= 4'h1;
    wait_ack(0);
    look(8);
    chk(32'(ends_seen - n0), 32'h0);
    // Internal source pending before enabling, source clearing on
    wr(dcs_pkg::REG_CTRL_HIGH, 32'h100);
    rd(dcs_pkg::REG_CTRL_LOW);
    int_set <= 4'h4;
    last_mask = 4'h4;
    wr(dcs_pkg::REG_CTRL_LOW, 32'h04);
    int_set <= 4'h0;
    look(12);
    rd(dcs_pkg::REG_CTRL_LOW);
    chk(d[2], 1'b0);
    @(posedge clk_sys);
    int_set <= 4'h4;
    look(3);
    chk(int_pass[2], 1'b1);
    // Module stop keeps interrupt settings and blocks register access
    wr(dcs_pkg::REG_CTRL_LOW, 32'h80);
    wr(dcs_pkg::REG_MOD_STOP, 32'h1);
    look(1);
    chk(module_stopped, 1'b1);
    rd(dcs_pkg::REG_CTRL_LOW);
    chk(d, 32'h0);
    rd(dcs_pkg::REG_STATUS);
    chk(d, 32'h1000);
    wr(dcs_pkg::REG_CTRL_LOW, 32'h0);
    look(1);
    chk(irq, 4'h8);
    wr(dcs_pkg::REG_MOD_STOP, 32'h0);
    rd(dcs_pkg::REG_CTRL_LOW);
    chk(d[7:0], 8'h80);
    // Edge sensing: a pin already low starts the first unit
    wr(dcs_pkg::REG_CTRL_HIGH, 32'h44404);
    want <= 4'h0;
    look(1);
    want <= 4'h1;
    last_mask = 4'h0;
    write_buffer_enable <= 1'b1;
    rd(dcs_pkg::REG_CTRL_LOW);
    wr(dcs_pkg::REG_CTRL_LOW, 32'h01);
    wait_ack(0);
    look(6);
    // Clock enable low: a write is ignored
    ce <= 1'b0;
    wr(dcs_pkg::REG_CTRL_LOW, 32'h0);
    ce <= 1'b1;
    rd(dcs_pkg::REG_CTRL_LOW);
    chk(d[7:0], 8'h01);
    report_and_stop;
  end
endmodule : dcs_channel_ctrl_tb_top
